// [calibration_diagnostic_registers.v]
`timescale 1ns/1ps
`include "cal_diag_defs.vh"

// Operation
// - gain middle and low bytes read/write
// - gain preloaded from factory trim, overwritable
// - offset subtracted first, then gain applied
// - serial check enables reset to 0x10
// - clock-count error only for chip-select frames
// - converter check enables reset to 0x07
// - logic check enables reset to 0x0d
// - 24-bit result read-only, zero after reset
// - summary flags OR converter, logic, serial
// - summary shows clock, overflow, unsettled directly
// - serial faults write-one-to-clear, tally read-only
// - clock tally advances every 64 cycles
// - converter fault register feeds summary flag
module calibration_diagnostic_registers
#(
  parameter TALLY_DIVIDE = `TALLY_DIVIDE  // master clocks per tally step
)
(
  input  wire        ref_clk_i,           // master clock, 50 MHz
  input  wire        reset_n_i,           // async reset, active low
  input  wire        ce_i,                // clock enable, freezes all
  input  wire        sclk_i,              // serial clock pin
  input  wire        cs_n_i,              // chip select pin, active low
  input  wire        sdi_i,               // serial data in pin
  output wire        sdo_o,               // serial data out pin
  input  wire [15:0] factory_gain_i,      // factory trim, low 16 bits
  input  wire [7:0]  gain_high_i,         // gain bits 23:16
  input  wire [23:0] offset_i,            // signed user offset
  input  wire [23:0] filter_data_i,       // signed filter output
  input  wire        filter_valid_i,      // filter output strobe
  input  wire        logic_reg_fault_i,   // digital regulator fault
  input  wire        analog_reg_fault_i,  // analog regulator fault
  input  wire        reference_fault_i,   // reference missing
  input  wire        overflow_fault_i,    // filter saturated
  input  wire        unsettled_fault_i,   // filter not settled
  input  wire        missing_clock_i,     // external clock absent
  input  wire        regmap_crc_fault_i,  // register map crc fault
  input  wire        ram_crc_fault_i,     // ram crc fault
  input  wire        fuse_crc_fault_i,    // fuse crc fault
  input  wire        serial_crc_fault_i,  // serial crc fault pulse
  output wire [23:0] gain_coeff_o,        // full gain coefficient
  output wire [23:0] conversion_result_o, // corrected result
  output wire [7:0]  summary_flags_o      // summary fault flags
);

  // ------------------
  // storage
  // ------------------
  reg  [7:0]  gain_mid_q;
  reg  [7:0]  gain_low_q;
  reg         trim_pending_q;
  reg  [7:0]  serial_en_q;
  reg  [7:0]  conv_en_q;
  reg  [7:0]  logic_en_q;
  reg  [23:0] result_q;
  reg  [4:0]  serial_flags_q;
  reg         por_q;
  reg  [7:0]  tally_q;
  reg  [7:0]  tally_div_q;
  reg  [23:0] rd_data_d;
  reg         mapped_d;
  reg         writable_d;

  wire        cmd;
  wire        cmd_read;
  wire [6:0]  cmd_addr;
  wire        wr;
  wire [7:0]  wr_data;
  wire        frame_end;
  wire        tally_fault;

  // ------------------
  // serial port
  // ------------------
  serial_frame_slave u_slave
  (
    .ref_clk_i     (ref_clk_i),
    .reset_n_i     (reset_n_i),
    .ce_i          (ce_i),
    .sclk_i        (sclk_i),
    .cs_n_i        (cs_n_i),
    .sdi_i         (sdi_i),
    .sdo_o         (sdo_o),
    .rd_data_i     (rd_data_d),
    .cmd_o         (cmd),
    .cmd_read_o    (cmd_read),
    .cmd_addr_o    (cmd_addr),
    .wr_o          (wr),
    .wr_data_o     (wr_data),
    .frame_end_o   (frame_end),
    .tally_fault_o (tally_fault)
  );

  // ------------------
  // live fault status
  // ------------------
  // each converter and logic source is gated by its own enable before any OR
  wire [7:0] conv_flags =
  {
    2'b00,
    logic_reg_fault_i  & conv_en_q[`CEN_LOGIC_REG],
    analog_reg_fault_i & conv_en_q[`CEN_ANALOG_REG],
    reference_fault_i  & conv_en_q[`CEN_REFERENCE],
    overflow_fault_i   & conv_en_q[`CEN_OVERFLOW],
    unsettled_fault_i  & conv_en_q[`CEN_UNSETTLED],
    missing_clock_i    & conv_en_q[`CEN_EXT_CLOCK]
  };
  wire [7:0] logic_flags =
  {
    3'b000,
    regmap_crc_fault_i & logic_en_q[`LEN_REGMAP_CRC],
    ram_crc_fault_i    & logic_en_q[`LEN_RAM_CRC],
    fuse_crc_fault_i   & logic_en_q[`LEN_FUSE_CRC],
    2'b00
  };
  // clock-absent fault goes to the summary only, not the converter OR
  wire conv_any   = |conv_flags[5:1];
  wire logic_any  = |logic_flags;
  wire serial_any = |serial_flags_q;
  wire [6:0] summary_low =
  {
    conv_any,
    logic_any,
    conv_flags[0],
    conv_flags[2],
    conv_flags[1],
    serial_any,
    por_q
  };
  wire [7:0] summary = {|summary_low[6:1], summary_low};

  assign summary_flags_o     = summary;
  assign gain_coeff_o        = {gain_high_i, gain_mid_q, gain_low_q};
  assign conversion_result_o = result_q;

  // ------------------
  // read mux and address map
  // ------------------
  // byte registers are left-aligned so the slave always shifts bit 23
  always @*
  begin
    rd_data_d  = 24'h000000;
    mapped_d   = 1'b1;
    writable_d = 1'b0;
    case (cmd_addr)
      `OFS_GAIN_MID:
      begin
        rd_data_d  = {gain_mid_q, 16'h0000};
        writable_d = 1'b1;
      end
      `OFS_GAIN_LOW:
      begin
        rd_data_d  = {gain_low_q, 16'h0000};
        writable_d = 1'b1;
      end
      `OFS_SERIAL_EN:
      begin
        rd_data_d  = {serial_en_q, 16'h0000};
        writable_d = 1'b1;
      end
      `OFS_CONV_EN:
      begin
        rd_data_d  = {conv_en_q, 16'h0000};
        writable_d = 1'b1;
      end
      `OFS_LOGIC_EN:
      begin
        rd_data_d  = {logic_en_q, 16'h0000};
        writable_d = 1'b1;
      end
      `OFS_RESULT:       rd_data_d = result_q;
      `OFS_SUMMARY:      rd_data_d = {summary, 16'h0000};
      `OFS_SERIAL_FLAGS:
      begin
        rd_data_d  = {3'b000, serial_flags_q, 16'h0000};
        writable_d = 1'b1;
      end
      `OFS_CONV_FLAGS:   rd_data_d = {conv_flags, 16'h0000};
      `OFS_LOGIC_FLAGS:  rd_data_d = {logic_flags, 16'h0000};
      `OFS_CLOCK_TALLY:  rd_data_d = {tally_q, 16'h0000};
      default:           mapped_d  = 1'b0;
    endcase
  end

  // ------------------
  // control registers
  // ------------------
  // trim is caught on the first enabled edge after release, not in reset
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      gain_mid_q     <= `RST_GAIN_BYTE;
      gain_low_q     <= `RST_GAIN_BYTE;
      trim_pending_q <= 1'b1;
      serial_en_q    <= `RST_SERIAL_EN;
      conv_en_q      <= `RST_CONV_EN;
      logic_en_q     <= `RST_LOGIC_EN;
    end
    else if (ce_i)
    begin
      if (trim_pending_q)
      begin
        trim_pending_q <= 1'b0;
        gain_mid_q     <= factory_gain_i[15:8];
        gain_low_q     <= factory_gain_i[7:0];
      end
      else if (wr)
      begin
        case (cmd_addr)
          `OFS_GAIN_MID:  gain_mid_q  <= wr_data;
          `OFS_GAIN_LOW:  gain_low_q  <= wr_data;
          `OFS_SERIAL_EN: serial_en_q <= wr_data & `MASK_SERIAL_EN;
          `OFS_CONV_EN:   conv_en_q   <= wr_data & `MASK_CONV_EN;
          `OFS_LOGIC_EN:  logic_en_q  <= wr_data & `MASK_LOGIC_EN;
          default:        trim_pending_q <= 1'b0;
        endcase
      end
    end
  end

  // ------------------
  // serial fault flags
  // ------------------
  wire [4:0] set_flags;
  wire [4:0] clr_flags;
  assign set_flags[`SF_IGNORE] = wr & mapped_d & ~writable_d &
                                 serial_en_q[`SEN_IGNORE];
  assign set_flags[`SF_TALLY]  = tally_fault & serial_en_q[`SEN_TALLY];
  assign set_flags[`SF_READ]   = cmd & cmd_read & ~mapped_d &
                                 serial_en_q[`SEN_READ];
  assign set_flags[`SF_WRITE]  = wr & ~mapped_d & serial_en_q[`SEN_WRITE];
  assign set_flags[`SF_CRC]    = serial_crc_fault_i;
  wire [7:0] w1c_bits = wr_data & `MASK_SERIAL_W1C;
  // tally flag is read-only: a clean framed transfer clears it
  assign clr_flags = (wr && cmd_addr == `OFS_SERIAL_FLAGS) ?
                     w1c_bits[4:0] :
                     {1'b0, frame_end & ~tally_fault, 3'b000};

  // set wins over a clear in the same cycle
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      serial_flags_q <= 5'b00000;
    else if (ce_i)
      serial_flags_q <= (serial_flags_q & ~clr_flags) | set_flags;
  end

  // power-on flag cleared by reading the summary register
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      por_q <= 1'b1;
    else if (ce_i && cmd && cmd_read && cmd_addr == `OFS_SUMMARY)
      por_q <= 1'b0;
  end

  // ------------------
  // clock tally
  // ------------------
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tally_div_q <= 8'h00;
      tally_q     <= 8'h00;
    end
    else if (ce_i && logic_en_q[`LEN_TALLY])
    begin
      if (tally_div_q == TALLY_DIVIDE[7:0] - 8'h01)
      begin
        tally_div_q <= 8'h00;
        tally_q     <= tally_q + 8'h01;
      end
      else
        tally_div_q <= tally_div_q + 8'h01;
    end
  end

  // ------------------
  // offset and gain correction
  // ------------------
  // nominal gain 0x400000 is unity, so 0x555555 gives 4/3
  wire signed [24:0] diff = $signed({filter_data_i[23], filter_data_i}) -
                            $signed({offset_i[23], offset_i});
  wire signed [49:0] product = diff * $signed({1'b0, gain_coeff_o});
  wire signed [27:0] scaled  = product[49:22];
  wire pos_sat = ~scaled[27] & (|scaled[26:23]);
  wire neg_sat = scaled[27] & ~(&scaled[26:23]);

  // saturate instead of wrapping on large gain or offset
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      result_q <= `RST_RESULT;
    else if (ce_i && filter_valid_i)
    begin
      if (pos_sat)
        result_q <= 24'h7fffff;
      else if (neg_sat)
        result_q <= 24'h800000;
      else
        result_q <= scaled[23:0];
    end
  end

endmodule // calibration_diagnostic_registers

// [cal_diag_defs.vh]
`ifndef CAL_DIAG_DEFS_VH
`define CAL_DIAG_DEFS_VH

// ------------------
// register offsets (7-bit serial address)
// ------------------
`define OFS_GAIN_MID        7'h25
`define OFS_GAIN_LOW        7'h26
`define OFS_SERIAL_EN       7'h28
`define OFS_CONV_EN         7'h29
`define OFS_LOGIC_EN        7'h2a
`define OFS_RESULT          7'h2c
`define OFS_SUMMARY         7'h2d
`define OFS_SERIAL_FLAGS    7'h2e
`define OFS_CONV_FLAGS      7'h2f
`define OFS_LOGIC_FLAGS     7'h30
`define OFS_CLOCK_TALLY     7'h31

// ------------------
// reset values and writable masks
// ------------------
`define RST_GAIN_BYTE       8'h00
`define RST_SERIAL_EN       8'h10
`define RST_CONV_EN         8'h07
`define RST_LOGIC_EN        8'h0d
`define RST_RESULT          24'h000000
`define MASK_SERIAL_EN      8'h1e
`define MASK_CONV_EN        8'h3f
`define MASK_LOGIC_EN       8'h1f
`define MASK_SERIAL_W1C     8'h17

// ------------------
// field positions
// ------------------
`define SEN_IGNORE          4
`define SEN_TALLY           3
`define SEN_READ            2
`define SEN_WRITE           1
`define CEN_LOGIC_REG       5
`define CEN_ANALOG_REG      4
`define CEN_REFERENCE       3
`define CEN_OVERFLOW        2
`define CEN_UNSETTLED       1
`define CEN_EXT_CLOCK       0
`define LEN_REGMAP_CRC      4
`define LEN_RAM_CRC         3
`define LEN_FUSE_CRC        2
`define LEN_TALLY           0
`define SF_IGNORE           4
`define SF_TALLY            3
`define SF_READ             2
`define SF_WRITE            1
`define SF_CRC              0

// ------------------
// timing and framing
// ------------------
`define TALLY_DIVIDE        64
`define FRAME_BITS_BYTE     6'd16
`define FRAME_BITS_RESULT   6'd32
`define HEADER_LAST_BIT     6'd7
`define BYTE_LAST_BIT       6'd15
`define GAIN_SHIFT          22

`endif

// [serial_frame_slave.v]
`timescale 1ns/1ps
`include "cal_diag_defs.vh"

// serial slave, mode 0: header = read flag + 7-bit address, then data
module serial_frame_slave
(
  input  wire        ref_clk_i,     // master clock
  input  wire        reset_n_i,     // async reset, active low
  input  wire        ce_i,          // clock enable
  input  wire        sclk_i,        // serial clock pin
  input  wire        cs_n_i,        // chip select pin, active low
  input  wire        sdi_i,         // serial data in pin
  output wire        sdo_o,         // serial data out
  input  wire [23:0] rd_data_i,     // left-aligned read data
  output reg         cmd_o,         // header received pulse
  output reg         cmd_read_o,    // header is a read
  output reg  [6:0]  cmd_addr_o,    // header address
  output reg         wr_o,          // write byte pulse
  output reg  [7:0]  wr_data_o,     // write byte
  output reg         frame_end_o,   // chip select released pulse
  output reg         tally_fault_o  // bit count wrong at frame end
);

  // ------------------
  // pin synchronisers
  // ------------------
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg [1:0] edge_q;
  reg [5:0] bit_cnt_q;
  reg [6:0] shift_q;
  reg [23:0] out_q;
  reg        sdo_q;

  wire sclk_s = sync2_q[0];
  wire cs_n_s = sync2_q[1];
  wire sdi_s  = sync2_q[2];
  wire sclk_rise = sclk_s & ~edge_q[0];
  wire sclk_fall = ~sclk_s & edge_q[0];
  wire cs_start  = ~cs_n_s & edge_q[1];
  wire cs_end    = cs_n_s & ~edge_q[1];
  wire [5:0] expect_bits = (cmd_read_o && cmd_addr_o == `OFS_RESULT) ?
                           `FRAME_BITS_RESULT : `FRAME_BITS_BYTE;

  assign sdo_o = sdo_q;

  // only the second stage is read by logic
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_q <= 3'b010;
      sync2_q <= 3'b010;
      edge_q  <= 2'b10;
    end
    else if (ce_i)
    begin
      sync1_q <= {sdi_i, cs_n_i, sclk_i};
      sync2_q <= sync1_q;
      edge_q  <= sync2_q[1:0];
    end
  end

  // ------------------
  // frame engine
  // ------------------
  // sclk must stay below a quarter of ref_clk for the read turnaround
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      bit_cnt_q     <= 6'd0;
      shift_q       <= 7'h00;
      out_q         <= 24'h000000;
      sdo_q         <= 1'b0;
      cmd_o         <= 1'b0;
      cmd_read_o    <= 1'b0;
      cmd_addr_o    <= 7'h00;
      wr_o          <= 1'b0;
      wr_data_o     <= 8'h00;
      frame_end_o   <= 1'b0;
      tally_fault_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cmd_o         <= 1'b0;
      wr_o          <= 1'b0;
      frame_end_o   <= 1'b0;
      tally_fault_o <= 1'b0;
      // load as the header lands, before a read can clear what it shows
      if (cmd_o && cmd_read_o)
        out_q <= rd_data_i;
      if (cs_start)
      begin
        bit_cnt_q <= 6'd0;
        out_q     <= 24'h000000;
        sdo_q     <= 1'b0;
      end
      else if (cs_end)
      begin
        frame_end_o   <= 1'b1;
        // count checked only on chip-select framed transfers
        tally_fault_o <= (bit_cnt_q != expect_bits);
      end
      else if (!cs_n_s && sclk_rise)
      begin
        shift_q <= {shift_q[5:0], sdi_s};
        if (bit_cnt_q != 6'h3f)
          bit_cnt_q <= bit_cnt_q + 6'd1;
        if (bit_cnt_q == `HEADER_LAST_BIT)
        begin
          cmd_o      <= 1'b1;
          cmd_read_o <= shift_q[6];
          cmd_addr_o <= {shift_q[5:0], sdi_s};
        end
        if (bit_cnt_q == `BYTE_LAST_BIT && !cmd_read_o)
        begin
          wr_o      <= 1'b1;
          wr_data_o <= {shift_q, sdi_s};
        end
      end
      else if (!cs_n_s && sclk_fall && bit_cnt_q > `HEADER_LAST_BIT)
      begin
        sdo_q <= out_q[23];
        out_q <= {out_q[22:0], 1'b0};
      end
    end
  end

endmodule // serial_frame_slave

// [calibration_diagnostic_registers_asserts.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------
// port checker for the calibration and diagnostic registers
// ----------------------------------------------------------
module cal_diag_checker
(
  input wire        ref_clk_i,           // master clock
  input wire        reset_n_i,           // async reset, active low
  input wire        ce_i,                // clock enable
  input wire [15:0] factory_gain_i,      // factory trim
  input wire [7:0]  gain_high_i,         // gain high byte
  input wire        filter_valid_i,      // filter strobe
  input wire        logic_reg_fault_i,   // digital regulator fault
  input wire        analog_reg_fault_i,  // analog regulator fault
  input wire        reference_fault_i,   // reference missing
  input wire        overflow_fault_i,    // filter saturated
  input wire        unsettled_fault_i,   // filter not settled
  input wire        missing_clock_i,     // external clock absent
  input wire        regmap_crc_fault_i,  // register map crc fault
  input wire        ram_crc_fault_i,     // ram crc fault
  input wire        fuse_crc_fault_i,    // fuse crc fault
  input wire [23:0] gain_coeff_o,        // full gain coefficient
  input wire [23:0] conversion_result_o, // corrected result
  input wire [7:0]  summary_flags_o      // summary fault flags
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // first edge after reset release, matched only if clock enable is high on that edge
  sequence s_release;
    $rose(reset_n_i) ##0 ce_i;
  endsequence

  // faults are live levels, so every summary bit except master (7), serial (1) and power-on (0) needs a present source
  a_master_or_ok: assert property (
    summary_flags_o[7] == |summary_flags_o[6:1])
    else $error("master error bit is not the or of bits 6 to 1");
  a_filter_into_conv: assert property (
    summary_flags_o[3] || summary_flags_o[2] |-> summary_flags_o[6])
    else $error("filter fault shown without converter summary");
  a_overflow_live: assert property (
    summary_flags_o[3] |-> overflow_fault_i)
    else $error("overflow flag without overflow source");
  a_clock_live: assert property (
    summary_flags_o[4] |-> missing_clock_i)
    else $error("missing clock flag without its source");
  a_logic_source: assert property (
    summary_flags_o[5] |->
    regmap_crc_fault_i || ram_crc_fault_i || fuse_crc_fault_i)
    else $error("logic summary set with no crc fault present");
  a_conv_source: assert property (
    summary_flags_o[6] |-> logic_reg_fault_i || analog_reg_fault_i ||
    reference_fault_i || overflow_fault_i || unsettled_fault_i)
    else $error("converter summary set with no converter fault");
  a_gain_high_pass: assert property (
    gain_coeff_o[23:16] == gain_high_i)
    else $error("gain high byte does not follow its input");
  a_result_hold: assert property (
    !filter_valid_i |=> $stable(conversion_result_o))
    else $error("result moved without a filter strobe");
  a_freeze_hold: assert property (
    !ce_i |=> $stable(conversion_result_o) && $stable(gain_coeff_o[15:0]))
    else $error("registers moved while clock enable was low");
  a_reset_state: assert property (
    s_release |-> summary_flags_o[0] && conversion_result_o == 24'h000000)
    else $error("power-on flag or zero result missing after reset");
  a_trim_load: assert property (
    s_release |=> gain_coeff_o[15:0] == $past(factory_gain_i))
    else $error("factory trim not loaded after reset");
endmodule // cal_diag_checker

bind calibration_diagnostic_registers cal_diag_checker u_chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
  .factory_gain_i(factory_gain_i), .gain_high_i(gain_high_i),
  .filter_valid_i(filter_valid_i), .logic_reg_fault_i(logic_reg_fault_i),
  .analog_reg_fault_i(analog_reg_fault_i),
  .reference_fault_i(reference_fault_i),
  .overflow_fault_i(overflow_fault_i),
  .unsettled_fault_i(unsettled_fault_i),
  .missing_clock_i(missing_clock_i),
  .regmap_crc_fault_i(regmap_crc_fault_i),
  .ram_crc_fault_i(ram_crc_fault_i), .fuse_crc_fault_i(fuse_crc_fault_i),
  .gain_coeff_o(gain_coeff_o), .conversion_result_o(conversion_result_o),
  .summary_flags_o(summary_flags_o));

// [spi_host_model.sv]
`timescale 1ns/1ps

// ---------------------------------------------
// serial host, mode 0, ten master clocks a half
// ---------------------------------------------
module spi_host_model
(
  input  wire logic clk_i,   // master clock
  input  wire logic sdo_i,   // device data out
  output logic      sclk_o,  // serial clock, idles low, pulsed by loose outside frames
  output logic      cs_n_o,  // chip select, active low
  output logic      sdi_o    // data to device
);
  // idle levels at time zero
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // half period well above the two-clock minimum of the synchroniser
  task automatic half();
    repeat (10) @(posedge clk_i);
  endtask

  // one framed access of nb rises; read bits shifted in after the header
  task automatic frame(input logic rd, input logic [6:0] adr,
                       input logic [7:0] wd, input int nb,
                       output logic [23:0] rv);
    logic [31:0] sh;
    sh = {rd, adr, wd, 16'h0000};
    rv = 24'h000000;
    cs_n_o <= 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      half();
      sclk_o <= 1'b0;
      sdi_o  <= sh[31 - i];
      half();
      sclk_o <= 1'b1;
      if (i >= 8)
        rv = {rv[22:0], sdo_i};
    end
    half();
    sclk_o <= 1'b0;
    half();
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o;  // released line shows no stale data
    half();
  endtask

  // clock pulses with chip select high, which must count for nothing
  task automatic loose(input int n);
    repeat (n)
    begin
      half();
      sclk_o <= 1'b1;
      half();
      sclk_o <= 1'b0;
    end
  endtask
endmodule // spi_host_model

// [tb_top.sv]
`timescale 1ns/1ps
`include "cal_diag_defs.vh"

module tb_top;
  localparam int DIV   = 4;      // shortened tally step
  localparam int LIMIT = 60000;  // cycle ceiling for a hang
  logic        clk, reset_n, ce, sclk, cs_n, sdi, sdo, fval, scrc;
  logic [15:0] trim;
  logic [7:0]  ghi, v0, summ;
  logic [8:0]  flt;
  logic [23:0] off, fdat, gain, res, rv, ex, gx;
  int          failures, total_checks, cycles, seed, t0, n, d;
  logic [6:0]  tadr [7] = '{`OFS_GAIN_MID, `OFS_GAIN_LOW, `OFS_SERIAL_EN,
                `OFS_CONV_EN, `OFS_LOGIC_EN, `OFS_SERIAL_FLAGS, `OFS_SUMMARY};
  logic [7:0]  tmsk [5] = '{8'hff, 8'hff, 8'h1e, 8'h3f, 8'h1f};
  logic [7:0]  trst [7];

  calibration_diagnostic_registers #(.TALLY_DIVIDE(DIV)) dut (
    .ref_clk_i(clk), .reset_n_i(reset_n), .ce_i(ce), .sclk_i(sclk),
    .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .factory_gain_i(trim),
    .gain_high_i(ghi), .offset_i(off), .filter_data_i(fdat),
    .filter_valid_i(fval), .logic_reg_fault_i(flt[5]),
    .analog_reg_fault_i(flt[4]), .reference_fault_i(flt[3]),
    .overflow_fault_i(flt[2]), .unsettled_fault_i(flt[1]),
    .missing_clock_i(flt[0]), .regmap_crc_fault_i(flt[8]),
    .ram_crc_fault_i(flt[7]), .fuse_crc_fault_i(flt[6]),
    .serial_crc_fault_i(scrc), .gain_coeff_o(gain), .conversion_result_o(res),
    .summary_flags_o(summ));

  spi_host_model host (.clk_i(clk), .sdo_i(sdo), .sclk_o(sclk),
    .cs_n_o(cs_n), .sdi_o(sdi));

  // summary expected from live faults and the enable masks
  function automatic logic [7:0] exp_sum(input logic [8:0] f,
                                         input logic [7:0] cm, lm);
    logic [5:0] c;
    logic [2:0] g;
    logic [7:0] s;
    c = f[5:0] & cm[5:0];
    g = f[8:6] & lm[4:2];
    s = {1'b0, |c[5:1], |g, c[0], c[2], c[1], 2'b00};
    s[7] = |s[6:1];
    return s;
  endfunction

  // offset first, then gain, then clip to 24 signed bits
  function automatic logic [23:0] exp_res(input logic [23:0] x, o, g);
    logic signed [49:0] p;
    p = ($signed({x[23], x}) - $signed({o[23], o})) * $signed({1'b0, g});
    p = p >>> 22;
    if (p > 50'sd8388607)
      return 24'h7fffff;
    if (p < -50'sd8388608)
      return 24'h800000;
    return p[23:0];
  endfunction

  task automatic check(input string nm, input logic [23:0] seen, e);
    total_checks++;
    if (seen !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, seen);
    end
  endtask

  task automatic rd(input logic [6:0] a);
    host.frame(1'b1, a, 8'h00, 16, rv);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [23:0] u;
    host.frame(1'b0, a, v, 16, u);
  endtask

  task automatic complete_run();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      failures++;
      complete_run();
    end
  end

  // main sequence
  initial
  begin
    seed = 32'hd269ecbc;
    {reset_n, fval, scrc, flt, off, fdat, cycles} = '0;
    ce   = 1'b1;
    trim = 16'($random(seed));
    ghi  = {1'b0, 7'($random(seed))};
    trst = '{trim[15:8], trim[7:0], 8'h10, 8'h07, 8'h0d, 8'h00, 8'h01};
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++)
    begin
      rd(tadr[i]);
      check("reset value", rv, 24'(trst[i]));
    end
    host.frame(1'b1, `OFS_RESULT, 8'h00, 32, rv);
    check("result after reset", rv, 24'h000000);
    for (int i = 0; i < 5; i++)
    begin
      v0 = (i < 2) ? 8'($random(seed)) : 8'hff;
      wr(tadr[i], v0);
      rd(tadr[i]);
      check("written register", rv, 24'(v0 & tmsk[i]));
      if (i < 2) gx[15 - 8 * i -: 8] = v0;
    end
    check("gain", gain, {ghi, gx[15:0]});
    // each serial fault in turn, bad bit count last
    wr(`OFS_RESULT, 8'h5a);
    rd(7'h40);
    check("unmapped read", rv, 24'h000000);
    wr(7'h40, 8'h11);
    @(posedge clk) scrc <= 1'b1;
    @(posedge clk) scrc <= 1'b0;
    host.frame(1'b0, `OFS_GAIN_MID, 8'h00, 12, rv);
    rd(`OFS_SERIAL_FLAGS);
    check("serial flags", rv, 24'h00001f);
    check("summary", 24'(summ), 24'h000082);
    wr(`OFS_SERIAL_FLAGS, 8'h05);
    rd(`OFS_SERIAL_FLAGS);
    check("partial clear", rv, 24'h000012);
    wr(`OFS_SERIAL_FLAGS, 8'h12);
    host.loose(5);
    rd(`OFS_SERIAL_FLAGS);
    check("cleared flags", rv, 24'h000000);
    wr(`OFS_SERIAL_EN, 8'h00);
    wr(`OFS_RESULT, 8'h5a);
    rd(7'h40);
    host.frame(1'b0, `OFS_GAIN_MID, 8'h00, 12, rv);
    rd(`OFS_SERIAL_FLAGS);
    check("disabled flags", rv, 24'h000000);
    // tally and live summary, all enabled then all disabled
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
      begin
        wr(`OFS_CONV_EN, 8'h00);
        wr(`OFS_LOGIC_EN, 8'h00);
      end
      rd(`OFS_CLOCK_TALLY);
      v0 = rv[7:0];
      t0 = cycles;
      rd(`OFS_CLOCK_TALLY);
      d = int'(8'(rv[7:0] - v0));
      n = (k == 0) ? (cycles - t0) / DIV : 0;
      check("tally step", 24'(d >= n - 1 && d <= n + 1), 24'h1);
      for (int j = 0; j < 12; j++)
      begin
        @(posedge clk) flt <= (j == 0) ? 9'h1ff : 9'($random(seed));
        @(negedge clk);
        ex = 24'(exp_sum(flt, k ? 8'h00 : 8'h3f, k ? 8'h00 : 8'h1f));
        check("summary", 24'(summ), ex);
      end
      rd(`OFS_CONV_FLAGS);
      check("conv flags", rv, 24'(flt[5:0]) & {24{k == 0}});
      rd(`OFS_LOGIC_FLAGS);
      check("logic flags", rv, 24'(flt[8:6]) << 2 & {24{k == 0}});
    end
    @(posedge clk) flt <= '0;
    // corrected results, first one clips
    for (int j = 0; j < 7; j++)
    begin
      @(posedge clk);
      off  <= (j == 0) ? 24'h800000 : 24'($random(seed));
      fdat <= (j == 0) ? 24'h7fffff : 24'($random(seed));
      fval <= 1'b1;
      ce   <= (j != 6);
      @(posedge clk);
      fval <= 1'b0;
      ce   <= 1'b1;
      @(negedge clk);
      ex = (j == 6) ? ex : exp_res(fdat, off, {ghi, gx[15:0]});
      check("result", res, ex);
      host.frame(1'b1, `OFS_RESULT, 8'h00, 32, rv);
      check("result read", rv, ex);
    end
    complete_run();
  end
endmodule // tb_top
